// file: design/ioa_arbiter.sv
`timescale 1ns/1ps
module ioa_arbiter #(
   parameter int unsigned        NSRC      = ioa_pkg::IOA_NSRC,
   parameter logic               LOCK_EN   = ioa_pkg::IOA_LOCK_AXI3,
   parameter logic [ioa_pkg::IOA_QW-1:0] QOS_FIXED = ioa_pkg::IOA_QOS_FIXED_RST
) (
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_resetn,
   input  ioa_pkg::ioa_qsel_e [NSRC-1:0]        i_qos_sel,
   input  wire logic [NSRC-1:0][ioa_pkg::IOA_QW-1:0] i_qos_prog,
   input  ioa_pkg::ioa_areq_s [NSRC-1:0]        i_ar_req,
   input  ioa_pkg::ioa_areq_s [NSRC-1:0]        i_aw_req,
   input  wire logic                            i_ar_done,
   input  wire logic                            i_aw_done,
   input  ioa_pkg::ioa_gmode_e                  i_guard_mode,
   input  wire logic                            i_one_tgt_en,
   input  ioa_pkg::ioa_ingr_s                   i_in_ar,
   input  ioa_pkg::ioa_ingr_s                   i_in_aw,
   input  wire logic [ioa_pkg::IOA_BW-1:0]      i_in_aw_beats,
   input  wire logic                            i_in_w_beat,
   input  wire logic                            i_in_r_done,
   input  wire logic [ioa_pkg::IOA_IDW-1:0]     i_in_r_id,
   input  wire logic                            i_in_b_done,
   input  wire logic [ioa_pkg::IOA_IDW-1:0]     i_in_b_id,
   output logic [NSRC-1:0]                      o_ar_grant,
   output logic [NSRC-1:0]                      o_aw_grant,
   output ioa_pkg::ioa_lock_e                   o_lock_state,
   output logic                                 o_in_ar_take,
   output logic                                 o_in_aw_take
);
   import ioa_pkg::*;

   localparam int unsigned RW = (NSRC > 1) ? $clog2(NSRC) : 1;

   typedef logic [NSRC-1:0][RW-1:0] ioa_rank_t;

   typedef struct packed {
      ioa_lock_e         lk;
      logic [RW-1:0]     lk_src;
      logic              lk_rd;
      logic              unl;
      logic [IOA_CW-1:0] out;
      logic [NSRC-1:0]   ar_gnt;
      logic [NSRC-1:0]   aw_gnt;
      ioa_rank_t         ar_rank;
      ioa_rank_t         aw_rank;
      logic              in_ar_take;
      logic              in_aw_take;
      logic [IOA_BW-1:0] tgt_beats;
      logic [IOA_DW-1:0] tgt_cur;
   } ioa_ast_s;

   // Winner: highest priority, then least recently used
   function automatic logic [NSRC-1:0] pick(
      input logic [NSRC-1:0]             v,
      input logic [NSRC-1:0][IOA_QW-1:0] q,
      input ioa_rank_t                   rk);
      logic [NSRC-1:0]   w;
      logic [IOA_QW-1:0] bq;
      logic [RW-1:0]     br;
      logic              hit;
      w = '0;
      bq = '0;
      br = '0;
      hit = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (v[i] && (!hit || q[i] > bq
                      || (q[i] == bq && rk[i] < br))) begin
            w = '0;
            w[i] = 1'b1;
            bq = q[i];
            br = rk[i];
            hit = 1'b1;
         end
      end
      return w;
   endfunction

   function automatic logic [RW-1:0] idx(input logic [NSRC-1:0] oh);
      logic [RW-1:0] r;
      r = '0;
      for (int i = 0; i < NSRC; i++)
         if (oh[i]) r = RW'(i);
      return r;
   endfunction

   // Granted source becomes most recent, those above it shift down
   function automatic ioa_rank_t touch(input ioa_rank_t rk,
                                       input logic [NSRC-1:0] w);
      ioa_rank_t     r;
      logic [RW-1:0] wr;
      r = rk;
      wr = rk[idx(w)];
      for (int i = 0; i < NSRC; i++) begin
         if (w[i]) r[i] = RW'(NSRC-1);
         else if ((|w) && rk[i] > wr) r[i] = rk[i] - 1'b1;
      end
      return r;
   endfunction

   function automatic ioa_rank_t rank_init();
      ioa_rank_t r;
      for (int i = 0; i < NSRC; i++)
         r[i] = RW'(i);
      return r;
   endfunction

   localparam ioa_rank_t RANK_RST = rank_init();

   ioa_ast_s                  st_r;
   ioa_ast_s                  st_nxt;
   logic [NSRC-1:0][IOA_QW-1:0] q_ar;
   logic [NSRC-1:0][IOA_QW-1:0] q_aw;
   logic [NSRC-1:0]           v_ar;
   logic [NSRC-1:0]           v_aw;
   logic [NSRC-1:0]           lk_ar;
   logic [NSRC-1:0]           lk_aw;
   logic [NSRC-1:0]           w_ar;
   logic [NSRC-1:0]           w_aw;
   logic [NSRC-1:0]           g_ar;
   logic [NSRC-1:0]           g_aw;
   logic [NSRC-1:0]           src_oh;
   logic                      ar_lock_w;
   logic                      aw_lock_w;
   logic                      ar_pass;
   logic                      aw_pass;
   logic                      tgt_ok;

   // Local priority and eligibility per source
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         case (i_qos_sel[i])
            IOA_QOS_PROG:   q_ar[i] = i_qos_prog[i];
            IOA_QOS_MASTER: q_ar[i] = i_ar_req[i].qos;
            default:        q_ar[i] = QOS_FIXED;
         endcase
         case (i_qos_sel[i])
            IOA_QOS_PROG:   q_aw[i] = i_qos_prog[i];
            IOA_QOS_MASTER: q_aw[i] = i_aw_req[i].qos;
            default:        q_aw[i] = QOS_FIXED;
         endcase
         v_ar[i] = i_ar_req[i].valid && !st_r.ar_gnt[i];
         v_aw[i] = i_aw_req[i].valid && !st_r.aw_gnt[i];
         lk_ar[i] = LOCK_EN && i_ar_req[i].lock;
         lk_aw[i] = LOCK_EN && i_aw_req[i].lock;
      end
   end

   assign w_ar = pick(v_ar, q_ar, st_r.ar_rank);
   assign w_aw = pick(v_aw, q_aw, st_r.aw_rank);
   assign ar_lock_w = |(w_ar & lk_ar);
   assign aw_lock_w = |(w_aw & lk_aw);
   assign src_oh = {{(NSRC-1){1'b0}}, 1'b1} << st_r.lk_src;
   assign tgt_ok = !i_one_tgt_en || (st_r.tgt_beats == '0)
                || (st_r.tgt_cur == i_in_aw.dest);

   // Independent read and write dependency trackers
   ioa_guard u_guard_rd (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_mode    (i_guard_mode),
      .i_req     (i_in_ar),
      .i_take    (st_r.in_ar_take),
      .i_done    (i_in_r_done),
      .i_done_id (i_in_r_id),
      .o_pass    (ar_pass)
   );

   ioa_guard u_guard_wr (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_mode    (i_guard_mode),
      .i_req     (i_in_aw),
      .i_take    (st_r.in_aw_take),
      .i_done    (i_in_b_done),
      .i_done_id (i_in_b_id),
      .o_pass    (aw_pass)
   );

   // Arbitration, lock sequencing, ingress acceptance
   always_comb begin
      st_nxt = st_r;
      g_ar = '0;
      g_aw = '0;
      case (st_r.lk)
         IOA_LK_IDLE: begin
            if (ar_lock_w) begin
               st_nxt.lk = IOA_LK_DRAIN;
               st_nxt.lk_src = idx(w_ar);
               st_nxt.lk_rd = 1'b1;
               if (!aw_lock_w) g_aw = w_aw;
            end else if (aw_lock_w) begin
               st_nxt.lk = IOA_LK_DRAIN;
               st_nxt.lk_src = idx(w_aw);
               st_nxt.lk_rd = 1'b0;
               g_ar = w_ar;
            end else begin
               g_ar = w_ar;
               g_aw = w_aw;
            end
         end
         IOA_LK_DRAIN: begin
            if (st_r.out == '0) begin
               if (st_r.lk_rd) g_ar = v_ar & src_oh;
               else g_aw = v_aw & src_oh;
               st_nxt.unl = 1'b0;
               if (|(g_ar | g_aw)) st_nxt.lk = IOA_LK_HELD;
            end
         end
         IOA_LK_HELD: begin
            if (!st_r.unl) begin
               g_ar = v_ar & src_oh;
               g_aw = v_aw & src_oh;
               if ((|(g_ar & ~lk_ar)) || (|(g_aw & ~lk_aw)))
                  st_nxt.unl = 1'b1;
            end
         end
         default: st_nxt.lk = IOA_LK_IDLE;
      endcase
      st_nxt.out = st_r.out + IOA_CW'(|g_ar) + IOA_CW'(|g_aw)
                 - IOA_CW'(i_ar_done) - IOA_CW'(i_aw_done);
      if (st_r.lk == IOA_LK_HELD && st_r.unl && st_nxt.out == '0)
         st_nxt.lk = IOA_LK_IDLE;
      st_nxt.ar_gnt = g_ar;
      st_nxt.aw_gnt = g_aw;
      st_nxt.ar_rank = touch(st_r.ar_rank, g_ar);
      st_nxt.aw_rank = touch(st_r.aw_rank, g_aw);
      st_nxt.in_ar_take = i_in_ar.valid && !st_r.in_ar_take && ar_pass;
      st_nxt.in_aw_take = i_in_aw.valid && !st_r.in_aw_take && aw_pass
                       && tgt_ok;
      st_nxt.tgt_beats = st_r.tgt_beats - IOA_BW'(i_in_w_beat)
                       + (st_r.in_aw_take ? i_in_aw_beats : '0);
      if (st_r.in_aw_take) st_nxt.tgt_cur = i_in_aw.dest;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
         st_r.lk <= IOA_LK_IDLE;
         st_r.ar_rank <= RANK_RST;
         st_r.aw_rank <= RANK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign o_ar_grant = st_r.ar_gnt;
   assign o_aw_grant = st_r.aw_gnt;
   assign o_lock_state = st_r.lk;
   assign o_in_ar_take = st_r.in_ar_take;
   assign o_in_aw_take = st_r.in_aw_take;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   property p_prio;
      (st_r.lk == IOA_LK_IDLE && lk_ar == '0 && v_ar[0] && v_ar[1]
       && q_ar[0] > q_ar[1]) |=> !o_ar_grant[1];
   endproperty
   a_prio: assert property (p_prio)
      else $error("lower priority read granted over higher");

   property p_lru;
      (st_r.lk == IOA_LK_IDLE && lk_aw == '0 && v_aw[0] && v_aw[1]
       && q_aw[0] == q_aw[1] && st_r.aw_rank[0] < st_r.aw_rank[1])
      |=> !o_aw_grant[1];
   endproperty
   a_lru: assert property (p_lru)
      else $error("equal priority tie not least recently used");

   property p_mru;
      o_ar_grant[0] |-> (st_r.ar_rank[0] == RW'(NSRC-1));
   endproperty
   a_mru: assert property (p_mru)
      else $error("granted source not moved to most recent");

   property p_lock_stall;
      (st_r.lk == IOA_LK_IDLE && ar_lock_w)
      |=> (st_r.lk == IOA_LK_DRAIN && o_ar_grant == '0);
   endproperty
   a_lock_stall: assert property (p_lock_stall)
      else $error("locked read not stalled after winning");

   property p_lock_only_src;
      (st_r.lk == IOA_LK_HELD)
      |-> (((o_ar_grant | o_aw_grant) & ~src_oh) == '0);
   endproperty
   a_lock_only_src: assert property (p_lock_only_src)
      else $error("non-lock source granted during lock");

   property p_drain;
      (st_r.lk == IOA_LK_DRAIN && st_r.out != '0) |=> (o_ar_grant == '0
       && o_aw_grant == '0);
   endproperty
   a_drain: assert property (p_drain)
      else $error("grant issued while lock still draining");

   property p_unlock;
      (st_r.lk == IOA_LK_HELD && st_r.unl && st_r.out == 1
       && (i_ar_done ^ i_aw_done)) |=> (st_r.lk == IOA_LK_IDLE);
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("sources not reopened after unlocking completion");

   property p_both_lock;
      (st_r.lk == IOA_LK_IDLE && ar_lock_w && aw_lock_w)
      |=> (st_r.lk_rd && o_aw_grant == '0);
   endproperty
   a_both_lock: assert property (p_both_lock)
      else $error("coincident locks did not favour read");

   property p_one_tgt;
      (i_one_tgt_en && st_r.tgt_beats != '0 && st_r.tgt_cur != i_in_aw.dest)
      |=> !o_in_aw_take;
   endproperty
   a_one_tgt: assert property (p_one_tgt)
      else $error("write address taken toward another target");

   property p_no_lock_axi4;
      (!LOCK_EN) |-> (st_r.lk == IOA_LK_IDLE);
   endproperty
   a_no_lock_axi4: assert property (p_no_lock_axi4)
      else $error("lock sequence entered without lock support");

   c_lock_seq: cover property (st_r.lk == IOA_LK_HELD
                               ##[1:40] st_r.lk == IOA_LK_IDLE);
   c_tie: cover property (v_aw[0] && v_aw[1] && q_aw[0] == q_aw[1]);
   c_tgt_stall: cover property (i_one_tgt_en && i_in_aw.valid && !tgt_ok);
endmodule

// file: design/ioa_pkg.sv
package ioa_pkg;
   // Operation
   // - Each transaction gets a priority: fixed, programmed, or from its master.
   // - Differing priorities are granted in fixed order, largest value wins.
   // - Equal priorities meeting in one cycle are resolved least recently used.
   // - Each ingress bridge guards reads and writes with independent trackers.
   // - Single-destination mode stalls a new destination until its type drains.
   // - Per-ID mode passes a transaction whose ID has nothing outstanding.
   // - Per-ID mode passes a matching ID aimed at the same destination.
   // - Per-ID mode stalls a matching ID aimed elsewhere until a pass holds.
   // - Single-active-target holds write address while other-target beats pend.
   // - Locked sequences exist only when the interface is built as AXI3.
   // - A winning locked request stalls; the other channel still grants an unlocked winner that cycle, then blocks.
   // - Lock drains all outstanding work, then opens only the lock source.
   // - Completion of the unlocking transaction reopens every source.
   // - Coincident locked read and write: read wins, write address stalls.

   localparam int unsigned IOA_NSRC = 4;
   localparam int unsigned IOA_QW   = 4;
   localparam int unsigned IOA_IDW  = 2;
   localparam int unsigned IOA_DW   = 2;
   localparam int unsigned IOA_CW   = 5;
   localparam int unsigned IOA_BW   = 9;
   localparam logic [IOA_QW-1:0] IOA_QOS_FIXED_RST = 4'h0;
   localparam logic              IOA_LOCK_AXI3     = 1'b1;

   typedef enum logic [1:0] {
      IOA_QOS_FIXED,
      IOA_QOS_PROG,
      IOA_QOS_MASTER
   } ioa_qsel_e;

   typedef enum logic {
      IOA_GUARD_SINGLE,
      IOA_GUARD_PER_ID
   } ioa_gmode_e;

   typedef enum logic [1:0] {
      IOA_LK_IDLE,
      IOA_LK_DRAIN,
      IOA_LK_HELD
   } ioa_lock_e;

   // Ingress address request
   typedef struct packed {
      logic               valid;
      logic [IOA_IDW-1:0] id;
      logic [IOA_DW-1:0]  dest;
   } ioa_ingr_s;

   // Address request at the arbitration node
   typedef struct packed {
      logic              valid;
      logic [IOA_QW-1:0] qos;
      logic              lock;
   } ioa_areq_s;
endpackage

// file: design/ioa_guard.sv
`timescale 1ns/1ps
module ioa_guard (
   input  wire logic               i_sys_clk,
   input  wire logic               i_resetn,
   input  ioa_pkg::ioa_gmode_e     i_mode,
   input  ioa_pkg::ioa_ingr_s      i_req,
   input  wire logic               i_take,
   input  wire logic               i_done,
   input  wire logic [ioa_pkg::IOA_IDW-1:0] i_done_id,
   output logic                    o_pass
);
   import ioa_pkg::*;

   localparam int unsigned NID = 1 << IOA_IDW;

   typedef struct packed {
      logic [IOA_CW-1:0]           tot;
      logic [IOA_DW-1:0]           cur;
      logic [NID-1:0][IOA_CW-1:0]  cnt;
      logic [NID-1:0][IOA_DW-1:0]  dst;
   } ioa_gst_s;

   ioa_gst_s st_r;
   ioa_gst_s st_nxt;

   // Tracker update on acceptance and completion
   always_comb begin
      st_nxt = st_r;
      st_nxt.tot = st_r.tot + IOA_CW'(i_take) - IOA_CW'(i_done);
      if (i_take) begin
         st_nxt.cur = i_req.dest;
      end
      for (int k = 0; k < NID; k++) begin
         st_nxt.cnt[k] = st_r.cnt[k]
                       + IOA_CW'(i_take && i_req.id == IOA_IDW'(k))
                       - IOA_CW'(i_done && i_done_id == IOA_IDW'(k));
         if (i_take && i_req.id == IOA_IDW'(k)) begin
            st_nxt.dst[k] = i_req.dest;
         end
      end
   end

   // Pass decision for the request on offer
   always_comb begin
      if (i_mode == IOA_GUARD_SINGLE) begin
         o_pass = (st_r.tot == '0) || (st_r.cur == i_req.dest);
      end else begin
         o_pass = (st_r.cnt[i_req.id] == '0)
               || (st_r.dst[i_req.id] == i_req.dest);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   property p_single_stall;
      (i_take && !i_done && i_mode == IOA_GUARD_SINGLE)
      |=> (!(i_req.valid && i_req.dest != $past(i_req.dest)) || !o_pass);
   endproperty
   a_single_stall: assert property (p_single_stall)
      else $error("single mode passed a second destination");

   property p_perid_stall;
      (i_take && !i_done && i_mode == IOA_GUARD_PER_ID)
      |=> (!(i_req.id == $past(i_req.id)
             && i_req.dest != $past(i_req.dest)) || !o_pass);
   endproperty
   a_perid_stall: assert property (p_perid_stall)
      else $error("per-ID mode passed a conflicting destination");

   property p_perid_same;
      (i_take && i_mode == IOA_GUARD_PER_ID)
      |=> ((i_req.id != $past(i_req.id))
           || (i_req.dest != $past(i_req.dest)) || o_pass);
   endproperty
   a_perid_same: assert property (p_perid_same)
      else $error("per-ID mode stalled a same-destination request");

   property p_count_up;
      (i_take && !i_done) |=> (st_r.tot == $past(st_r.tot) + 1'b1);
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("outstanding count did not rise on acceptance");

   c_guard_stall: cover property (i_req.valid && !o_pass ##1 o_pass);
endmodule

// file: dv/ioa_far_model.sv
`timescale 1ns/1ps
module ioa_far_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_resetn,
   input  wire logic [3:0] i_ar_grant,
   input  wire logic [3:0] i_aw_grant,
   input  wire logic       i_hold,
   input  wire logic       i_slow,
   output logic            o_ar_done,
   output logic            o_aw_done
);
   int ar_n;
   int aw_n;
   int tmr;
   // Retire granted work, at most one read and one write response per pause
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ar_n <= 0;
         aw_n <= 0;
         tmr <= 0;
         o_ar_done <= 1'h0;
         o_aw_done <= 1'h0;
      end else begin
         ar_n <= ar_n + $countones(i_ar_grant) - int'(o_ar_done);
         aw_n <= aw_n + $countones(i_aw_grant) - int'(o_aw_done);
         if (!i_hold && tmr >= (i_slow ? 5 : 1)) begin
            tmr <= 0;
            o_ar_done <= ar_n > int'(o_ar_done);
            o_aw_done <= aw_n > int'(o_aw_done);
         end else begin
            tmr <= (i_hold || ar_n + aw_n == 0) ? 0 : tmr + 1;
            o_ar_done <= 1'h0;
            o_aw_done <= 1'h0;
         end
      end
   end
endmodule

// file: dv/ioa_arbiter_tb.sv
`timescale 1ns/1ps
module ioa_arbiter_tb;
   import ioa_pkg::*;
   localparam logic [3:0] QF = 4'h5;
   logic            clk = 1'h0;
   logic            rst_n = 1'h0;
   ioa_qsel_e [3:0] qsel = '{default: IOA_QOS_FIXED};
   logic [3:0][3:0] qprog = '0;
   ioa_areq_s [3:0] arq = '0;
   ioa_areq_s [3:0] awq = '0;
   ioa_gmode_e      gmode = IOA_GUARD_SINGLE;
   ioa_ingr_s       iar = '0;
   ioa_ingr_s       iaw = '0;
   logic [8:0]      beats = '0;
   logic [1:0]      rid = '0;
   logic [1:0]      bid = '0;
   logic            one_tgt = 1'h0;
   logic            wbeat = 1'h0;
   logic            rdone = 1'h0;
   logic            bdone = 1'h0;
   logic            hold = 1'h0;
   logic            slow = 1'h0;
   logic            ard;
   logic            awd;
   logic [3:0]      arg;
   logic [3:0]      awg;
   ioa_lock_e       lks;
   wire  [1:0]      tk;
   logic [31:0]     seed = 32'hBA2C;
   int              num_errors = 0;
   int              check_count = 0;
   int              tcnt[2] = '{0, 0};
   int              ofs[2];
   int              rk[2][4];
   int              gq[2][$];

   // Clock
   always #12.5 clk = ~clk;

   ioa_arbiter #(.NSRC(4), .LOCK_EN(1'h1), .QOS_FIXED(QF)) dut (
      .i_sys_clk(clk), .i_resetn(rst_n), .i_qos_sel(qsel),
      .i_qos_prog(qprog), .i_ar_req(arq), .i_aw_req(awq),
      .i_ar_done(ard), .i_aw_done(awd), .i_guard_mode(gmode),
      .i_one_tgt_en(one_tgt), .i_in_ar(iar), .i_in_aw(iaw),
      .i_in_aw_beats(beats), .i_in_w_beat(wbeat), .i_in_r_done(rdone),
      .i_in_r_id(rid), .i_in_b_done(bdone), .i_in_b_id(bid),
      .o_ar_grant(arg), .o_aw_grant(awg), .o_lock_state(lks),
      .o_in_ar_take(tk[0]), .o_in_aw_take(tk[1]));

   ioa_far_model far (
      .i_sys_clk(clk), .i_resetn(rst_n), .i_ar_grant(arg),
      .i_aw_grant(awg), .i_hold(hold), .i_slow(slow),
      .o_ar_done(ard), .o_aw_done(awd));

   // Record grants and takes, release the requests they answer
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (arg[i]) begin
            gq[0].push_back(i);
            arq[i].valid <= 1'h0;
         end
         if (awg[i]) begin
            gq[1].push_back(i);
            awq[i].valid <= 1'h0;
         end
      end
      if (tk[0]) begin
         tcnt[0]++;
         iar.valid <= 1'h0;
      end
      if (tk[1]) begin
         tcnt[1]++;
         iaw.valid <= 1'h0;
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [3:0] effq(input bit ch, input int i);
      case (qsel[i])
         IOA_QOS_FIXED: return QF;
         IOA_QOS_PROG:  return qprog[i];
         default:       return ch ? awq[i].qos : arq[i].qos;
      endcase
   endfunction

   // Highest priority wins, ties go to the least recent source
   function automatic int pick(input bit ch, input logic [3:0] v);
      int b;
      b = -1;
      for (int j = 0; j < 4; j++) begin
         if (v[rk[ch][j]] && (b < 0 || effq(ch, rk[ch][j]) > effq(ch, b)))
            b = rk[ch][j];
      end
      return b;
   endfunction

   function automatic void touch(input bit ch, input int w);
      int p;
      for (int j = 0; j < 4; j++) begin
         if (rk[ch][j] == w) p = j;
      end
      for (int j = p; j < 3; j++) rk[ch][j] = rk[ch][j + 1];
      rk[ch][3] = w;
   endfunction

   function automatic logic [3:0] vld(input bit ch);
      for (int i = 0; i < 4; i++) vld[i] = ch ? awq[i].valid : arq[i].valid;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One arbitration round over the given sources, random or equal priorities
   task automatic arb(input bit ch, input logic [3:0] v, input bit same);
      logic [31:0] r;
      int e[$];
      int w;
      gq[ch].delete();
      @(posedge clk);
      slow <= seed[0];
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         qsel[i] <= same ? IOA_QOS_MASTER : ioa_qsel_e'(r[1:0] % 2'h3);
         qprog[i] <= r[7:4];
         if (ch) awq[i] <= '{v[i], same ? 4'h7 : r[11:8], 1'h0};
         else arq[i] <= '{v[i], same ? 4'h7 : r[11:8], 1'h0};
      end
      #1;
      while (v != 4'h0) begin
         w = pick(ch, v);
         e.push_back(w);
         v[w] = 1'h0;
         touch(ch, w);
      end
      for (int k = 0; k < 60 && vld(ch) != 4'h0; k++) begin
         @(posedge clk);
         #1;
      end
      chk(gq[ch].size(), e.size());
      foreach (e[j]) chk(gq[ch][j], e[j]);
   endtask

   task automatic waitq(input bit ch, input int n);
      for (int k = 0; k < 60 && gq[ch].size() < n; k++) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic offer(input bit ch, input logic [1:0] id, dest,
                        input logic [8:0] bt);
      ofs[ch] = tcnt[ch];
      @(posedge clk);
      if (ch) begin
         iaw <= '{1'h1, id, dest};
         beats <= bt;
      end else begin
         iar <= '{1'h1, id, dest};
      end
   endtask

   task automatic want(input bit ch, input bit exp, input int n);
      for (int k = 0; k < n && tcnt[ch] == ofs[ch]; k++) begin
         @(posedge clk);
         #1;
      end
      chk(tcnt[ch] != ofs[ch], exp);
   endtask

   // Pulse a read done, a write done or a data beat
   task automatic pulse(input int k, input logic [1:0] id);
      @(posedge clk);
      case (k)
         0: begin
            rdone <= 1'h1;
            rid <= id;
         end
         1: begin
            bdone <= 1'h1;
            bid <= id;
         end
         default: wbeat <= 1'h1;
      endcase
      @(posedge clk);
      rdone <= 1'h0;
      bdone <= 1'h0;
      wbeat <= 1'h0;
   endtask

   // Main sequence
   initial begin
      logic [31:0] r;
      for (int c = 0; c < 2; c++) begin
         for (int j = 0; j < 4; j++) rk[c][j] = j;
      end
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      arb(0, 4'hF, 1);
      arb(0, 4'hC, 1);
      arb(0, 4'hF, 1);
      arb(1, 4'h6, 1);
      arb(1, 4'hF, 1);
      repeat (16) begin
         r = rnd();
         arb(r[0], r[4:1], 0);
      end
      offer(0, 2'h0, 2'h1, 9'h0);
      want(0, 1, 8);
      offer(0, 2'h1, 2'h2, 9'h0);
      want(0, 0, 8);
      offer(1, 2'h0, 2'h2, 9'h1);
      want(1, 1, 8);
      pulse(0, 2'h0);
      want(0, 1, 8);
      pulse(0, 2'h1);
      pulse(1, 2'h0);
      pulse(2, 2'h0);
      @(posedge clk);
      gmode <= IOA_GUARD_PER_ID;
      offer(0, 2'h1, 2'h1, 9'h0);
      want(0, 1, 8);
      offer(0, 2'h2, 2'h2, 9'h0);
      want(0, 1, 8);
      offer(0, 2'h1, 2'h1, 9'h0);
      want(0, 1, 8);
      offer(0, 2'h1, 2'h3, 9'h0);
      want(0, 0, 8);
      pulse(0, 2'h1);
      want(0, 0, 6);
      pulse(0, 2'h1);
      want(0, 1, 8);
      @(posedge clk);
      one_tgt <= 1'h1;
      offer(1, 2'h0, 2'h1, 9'h2);
      want(1, 1, 8);
      offer(1, 2'h1, 2'h2, 9'h1);
      want(1, 0, 8);
      pulse(2, 2'h0);
      want(1, 0, 6);
      pulse(2, 2'h0);
      want(1, 1, 8);
      @(posedge clk);
      hold <= 1'h1;
      qsel <= '{default: IOA_QOS_MASTER};
      gq[0].delete();
      gq[1].delete();
      arq[0] <= '{1'h1, 4'h1, 1'h0};
      waitq(0, 1);
      @(posedge clk);
      arq[1] <= '{1'h1, 4'h2, 1'h1};
      arq[3] <= '{1'h1, 4'h0, 1'h0};
      awq[2] <= '{1'h1, 4'h1, 1'h0};
      waitq(1, 1);
      chk(gq[1][0], 2);
      chk(lks, IOA_LK_DRAIN);
      chk(gq[0].size(), 1);
      @(posedge clk);
      hold <= 1'h0;
      waitq(0, 2);
      chk(gq[0][1], 1);
      chk(lks, IOA_LK_HELD);
      repeat (6) @(posedge clk);
      chk(gq[0].size(), 2);
      arq[1] <= '{1'h1, 4'h2, 1'h0};
      waitq(0, 4);
      chk(gq[0][2], 1);
      chk(gq[0][3], 3);
      chk(lks, IOA_LK_IDLE);
      @(posedge clk);
      gq[0].delete();
      gq[1].delete();
      arq[0] <= '{1'h1, 4'h1, 1'h1};
      awq[1] <= '{1'h1, 4'h1, 1'h1};
      waitq(0, 1);
      chk(gq[0][0], 0);
      chk(gq[1].size(), 0);
      @(posedge clk);
      arq[0] <= '{1'h1, 4'h1, 1'h0};
      waitq(1, 1);
      chk(gq[0].size(), 2);
      chk(gq[1][0], 1);
      chk(lks, IOA_LK_HELD);
      complete_run();
   end

   // Cut a hung run short
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
